// file: core/kh_pkg.sv
// Purpose: shared constants and types of the management keyhole bridge
// Assumes: 32-bit data, 10-bit link and management addresses
// Notes: bit numbers here are LSB-first; the command word's
//        MSB-first bit 16 is bit 15 here, bit 21 is bit 10
package kh_pkg;
   localparam int DW = 32;
   localparam int LAW = 10;
   localparam int MAW = 10;
   localparam int PAW = 8;
   // link word offsets of the bridge
   localparam logic [LAW-1:0] LK_BASE_DEF = 10'h030;
   localparam logic [LAW-1:0] OFS_DATA = 10'h001;
   localparam logic [LAW-1:0] OFS_CMD = 10'h002;
   localparam logic [LAW-1:0] OFS_RDY = 10'h003;
   // command word layout
   localparam int CMD_WR_BIT = 15;
   localparam int CMD_PCS_BIT = 10;
   // management space addresses
   localparam logic [MAW-1:0] MGMT_CFG_ADDR = 10'h340;
   localparam logic [MAW-1:0] MIIM_WDATA_ADDR = 10'h3B0;
   localparam logic [MAW-1:0] MIIM_ADDR_ADDR = 10'h3B4;
   // pcs selector layout
   localparam int SEL_PHY_LSB = 5;
   localparam int SEL_REG_LSB = 0;
   localparam int SEL_FW = 5;
   localparam int SEL_W = 10;
   // ready status bits, both ready out of reset
   localparam int RDY_RD_BIT = 1;
   localparam int RDY_WR_BIT = 2;
   localparam logic RDY_RESET = 1'b1;
   localparam logic [DW-1:0] CFG_WORD_DEF = 32'h00000034;
   // controller apb map
   localparam logic [PAW-1:0] A_CTRL = 8'h00;
   localparam logic [PAW-1:0] A_TADDR = 8'h04;
   localparam logic [PAW-1:0] A_SEL = 8'h08;
   localparam logic [PAW-1:0] A_WDATA = 8'h0C;
   localparam logic [PAW-1:0] A_RDATA = 8'h10;
   localparam logic [PAW-1:0] A_STATUS = 8'h14;
   localparam logic [PAW-1:0] A_CFGW = 8'h18;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_CFG_BIT = 2;
   localparam int OPW = 2;
   localparam logic [OPW-1:0] OP_MAC_WR = 2'h0;
   localparam logic [OPW-1:0] OP_MAC_RD = 2'h1;
   localparam logic [OPW-1:0] OP_PCS_WR = 2'h2;
   localparam logic [OPW-1:0] OP_PCS_RD = 2'h3;
   localparam int STEPW = 3;
   typedef enum logic [2:0] {
      STP_DATA_WR, STP_CMD_WR, STP_DATA_RD, STP_POLL_WR, STP_POLL_RD, STP_END
   } kh_step_t;
   typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_WAIT} kh_hst_t;
endpackage

// file: core/kh_link_if.sv
// Purpose: control link between controller and bridge
// Assumes: both ends on ref_clk; req held until a one-cycle ack
// Notes: rdata valid in the ack cycle only
`timescale 1ns/1ps
interface kh_link_if;
   logic req;
   logic wr;
   logic [kh_pkg::LAW-1:0] addr;
   logic [kh_pkg::DW-1:0] wdata;
   logic [kh_pkg::DW-1:0] rdata;
   logic ack;
   modport dev (input req, input wr, input addr, input wdata,
      output rdata, output ack);
   modport host (output req, output wr, output addr, output wdata,
      input rdata, input ack);
endinterface

// file: core/kh_mgmt_port.sv
// Purpose: one management access at a time towards the mac core
// Assumes: mac answers with a one-cycle mgmt_ack while mgmt_req is high
// Notes: done pulses the cycle after the ack, with rdata captured
`timescale 1ns/1ps
module kh_mgmt_port
   import kh_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic wr,
   input wire logic [kh_pkg::MAW-1:0] addr,
   input wire logic [kh_pkg::DW-1:0] wdata,
   output logic done,
   output logic [kh_pkg::DW-1:0] rdata,
   output logic mgmt_req,
   output logic mgmt_wr,
   output logic [kh_pkg::MAW-1:0] mgmt_addr,
   output logic [kh_pkg::DW-1:0] mgmt_wdata,
   input wire logic mgmt_ack,
   input wire logic [kh_pkg::DW-1:0] mgmt_rdata
);
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         mgmt_req <= 1'b0;
         mgmt_wr <= 1'b0;
         mgmt_addr <= '0;
         mgmt_wdata <= '0;
      end else if (start) begin
         // request fields frozen so later data writes cannot disturb it
         mgmt_req <= 1'b1;
         mgmt_wr <= wr;
         mgmt_addr <= addr;
         mgmt_wdata <= wdata;
      end else if (mgmt_ack) begin
         mgmt_req <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         done <= 1'b0;
         rdata <= '0;
      end else begin
         done <= mgmt_req & mgmt_ack;
         if (mgmt_req & mgmt_ack) begin
            rdata <= mgmt_rdata;
         end
      end
   end
endmodule

// file: core/kh_bridge_dev.sv
// Purpose: keyhole bridge from the control link into mac management space
// Assumes: host keeps req high until ack; mac side on the same clock
// Notes: data and command accesses stall while a management access runs;
//        ready status reads answer at once, except while a data hold read waits
`timescale 1ns/1ps
module kh_bridge_dev
   import kh_pkg::*;
#(
   parameter logic [kh_pkg::LAW-1:0] LINK_BASE = kh_pkg::LK_BASE_DEF
) (
   input wire logic ref_clk,
   input wire logic nrst,
   kh_link_if.dev lk,
   output logic mgmt_req,
   output logic mgmt_wr,
   output logic [kh_pkg::MAW-1:0] mgmt_addr,
   output logic [kh_pkg::DW-1:0] mgmt_wdata,
   input wire logic mgmt_ack,
   input wire logic [kh_pkg::DW-1:0] mgmt_rdata
);
   logic [DW-1:0] bridge_data_hold;
   logic [MAW-1:0] armed_addr;
   logic rd_armed, rd_wait, op_rd, rdy_rd, rdy_wr;
   logic p_start, p_wr, p_done, port_idle;
   logic [MAW-1:0] p_addr;
   logic [DW-1:0] p_rdata, bridge_ready_status, lk_rdata;
   logic is_data, is_cmd, is_rdy, hit, cmd_take, cmd_start, drd_any;
   logic drd_start, take, lk_ack;
   logic [MAW-1:0] mgmt_target_addr;

   //////////////////////////////////////////////////////////////////////
   assign lk.ack = lk_ack;
   assign lk.rdata = lk_rdata;
   assign mgmt_target_addr = lk.wdata[MAW-1:0];
   assign is_data = lk.addr == LINK_BASE + OFS_DATA; // [R11]
   assign is_cmd = lk.addr == LINK_BASE + OFS_CMD; // [R11]
   assign is_rdy = lk.addr == LINK_BASE + OFS_RDY;
   assign port_idle = !mgmt_req & !p_done;
   assign hit = lk.req & !lk_ack & !rd_wait;
   assign cmd_take = hit & lk.wr & is_cmd & port_idle;
   // bit 21 set is no defined command: taken and dropped
   assign cmd_start = cmd_take & !lk.wdata[CMD_PCS_BIT]
      & (lk.wdata[CMD_WR_BIT] | mgmt_target_addr == MIIM_ADDR_ADDR); // [R2]
   assign drd_any = !lk.wr & is_data & rd_armed;
   assign drd_start = hit & drd_any & port_idle; // [R8]
   assign p_start = cmd_start | drd_start;
   assign p_wr = cmd_start & lk.wdata[CMD_WR_BIT]; // [R2]
   assign p_addr = cmd_start ? mgmt_target_addr : armed_addr;
   assign take = hit & !drd_any & (!(is_data | is_cmd) | port_idle);

   always_comb begin
      bridge_ready_status = '0;
      bridge_ready_status[RDY_RD_BIT] = rdy_rd;
      bridge_ready_status[RDY_WR_BIT] = rdy_wr;
   end

   // selector in data hold rides as write data of the pcs read [R12]
   kh_mgmt_port u_port (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .start(p_start),
      .wr(p_wr),
      .addr(p_addr),
      .wdata(bridge_data_hold),
      .done(p_done),
      .rdata(p_rdata),
      .mgmt_req(mgmt_req),
      .mgmt_wr(mgmt_wr),
      .mgmt_addr(mgmt_addr),
      .mgmt_wdata(mgmt_wdata),
      .mgmt_ack(mgmt_ack),
      .mgmt_rdata(mgmt_rdata)
   );

   //////////////////////////////////////////////////////////////////////
   // link answers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         lk_ack <= 1'b0;
         lk_rdata <= '0;
         rd_wait <= 1'b0;
      end else begin
         lk_ack <= take | (rd_wait & p_done);
         if (rd_wait & p_done) begin
            lk_rdata <= p_rdata; // [R8]
         end else if (take & !lk.wr & is_rdy) begin
            lk_rdata <= bridge_ready_status;
         end else if (take & !lk.wr & is_data) begin
            lk_rdata <= bridge_data_hold;
         end else begin
            lk_rdata <= '0;
         end
         if (drd_start) begin
            rd_wait <= 1'b1;
         end else if (p_done) begin
            rd_wait <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // data hold and read arming
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         bridge_data_hold <= '0;
         rd_armed <= 1'b0;
         armed_addr <= '0;
         op_rd <= 1'b0;
      end else begin
         if (take & lk.wr & is_data) begin
            bridge_data_hold <= lk.wdata;
         end else if (p_done & op_rd) begin
            bridge_data_hold <= p_rdata; // [R14]
         end
         if (cmd_take) begin
            rd_armed <= !lk.wdata[CMD_PCS_BIT] & !lk.wdata[CMD_WR_BIT]
               & mgmt_target_addr != MIIM_ADDR_ADDR; // [R8]
            armed_addr <= mgmt_target_addr;
         end else if (drd_start) begin
            rd_armed <= 1'b0;
         end
         if (p_start) begin
            op_rd <= !p_wr;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // ready bits: cleared at start, set at completion
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdy_rd <= RDY_RESET;
         rdy_wr <= RDY_RESET;
      end else begin
         if (p_start & !p_wr) begin
            rdy_rd <= 1'b0; // [R13]
         end else if (p_done & op_rd) begin
            rdy_rd <= 1'b1; // [R10] [R13]
         end
         if (p_start & p_wr) begin
            rdy_wr <= 1'b0; // [R13]
         end else if (p_done & !op_rd) begin
            rdy_wr <= 1'b1; // [R13]
         end
      end
   end
endmodule

// file: core/kh_ctrl_host.sv
// Purpose: controller that drives the keyhole bridge on software's order
// Assumes: apb master per the usual two-phase protocol
// Notes: pready answers in the second access cycle; orders written while
//        busy are dropped, so poll busy before writing ctrl
//
// Function
// R1 - load data hold, then command with address
// R2 - command bit 16 set, 21 clear writes
// R3 - poll ready after write, optional
// R4 - pcs write: data, 3B0, selector, 3B4
// R5 - selector is phy address above register number
// R6 - config word written before any pcs access
// R7 - mac read: command with both bits clear
// R8 - reading data hold starts the direct read
// R9 - pcs read: selector, 3B4, poll, read data
// R10 - ready bit marks pcs read result present
// R11 - data hold at base+1, command base+2
// R12 - phy and register fields of selector
// R13 - ready bit cleared at start, set after
// R14 - read value held until next write
`timescale 1ns/1ps
module kh_ctrl_host
   import kh_pkg::*;
#(
   parameter logic [kh_pkg::LAW-1:0] LINK_BASE = kh_pkg::LK_BASE_DEF
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [kh_pkg::PAW-1:0] paddr,
   input wire logic [kh_pkg::DW-1:0] pwdata,
   output logic [kh_pkg::DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   kh_link_if.host lk
);
   logic [DW-1:0] wdata_reg, cfg_word, rd_result;
   logic [MAW-1:0] taddr;
   logic [SEL_FW-1:0] phy_select, reg_num;
   logic [SEL_W-1:0] sel_word;
   logic [OPW-1:0] op;
   logic [STEPW-1:0] step;
   logic busy, done, cfg_done, cfg_phase;
   logic apb_we, apb_re, wr_ctrl, clr_done, end_set, mapped;
   logic lk_req, lk_wr;
   logic [LAW-1:0] lk_addr;
   logic [DW-1:0] lk_wdata;
   kh_hst_t state;
   kh_step_t step_kind;
   logic [DW-1:0] step_val;

   function automatic logic [DW-1:0] cmd_word(input logic [MAW-1:0] a,
      input logic w);
      logic [DW-1:0] v;
      v = '0;
      v[MAW-1:0] = a;
      v[CMD_WR_BIT] = w; // [R2] [R7]
      return v;
   endfunction

   //////////////////////////////////////////////////////////////////////
   assign lk.req = lk_req;
   assign lk.wr = lk_wr;
   assign lk.addr = lk_addr;
   assign lk.wdata = lk_wdata;
   assign apb_we = psel & penable & pready & pwrite;
   assign apb_re = psel & penable & !pready & !pwrite;
   assign wr_ctrl = apb_we & paddr == A_CTRL;
   assign clr_done = apb_we & paddr == A_STATUS & pwdata[ST_DONE_BIT];
   assign end_set = state == HS_ISSUE & step_kind == STP_END & !cfg_phase;
   assign mapped = paddr == A_CTRL | paddr == A_TADDR | paddr == A_SEL
      | paddr == A_WDATA | paddr == A_RDATA | paddr == A_STATUS
      | paddr == A_CFGW;

   always_comb begin
      sel_word = '0;
      sel_word[SEL_PHY_LSB +: SEL_FW] = phy_select; // [R5] [R12]
      sel_word[SEL_REG_LSB +: SEL_FW] = reg_num; // [R12]
   end

   // step table of each order; the config prefix runs first
   always_comb begin
      step_kind = STP_END;
      step_val = '0;
      if (cfg_phase) begin
         case (step)
            3'h0: begin
               step_kind = STP_DATA_WR;
               step_val = cfg_word; // [R6]
            end
            3'h1: begin
               step_kind = STP_CMD_WR;
               step_val = cmd_word(MGMT_CFG_ADDR, 1'b1); // [R6]
            end
            3'h2: step_kind = STP_POLL_WR;
            default: step_kind = STP_END;
         endcase
      end else begin
         case ({op, step})
            {OP_MAC_WR, 3'h0}: begin
               step_kind = STP_DATA_WR;
               step_val = wdata_reg; // [R1]
            end
            {OP_MAC_WR, 3'h1}: begin
               step_kind = STP_CMD_WR;
               step_val = cmd_word(taddr, 1'b1); // [R1] [R2]
            end
            {OP_MAC_WR, 3'h2}: step_kind = STP_POLL_WR; // [R3]
            {OP_MAC_RD, 3'h0}: begin
               step_kind = STP_CMD_WR;
               step_val = cmd_word(taddr, 1'b0); // [R7]
            end
            {OP_MAC_RD, 3'h1}: step_kind = STP_DATA_RD; // [R7]
            {OP_PCS_WR, 3'h0}: begin
               step_kind = STP_DATA_WR;
               step_val = wdata_reg; // [R4]
            end
            {OP_PCS_WR, 3'h1}: begin
               step_kind = STP_CMD_WR;
               step_val = cmd_word(MIIM_WDATA_ADDR, 1'b1); // [R4]
            end
            {OP_PCS_WR, 3'h2}: begin
               step_kind = STP_DATA_WR;
               step_val = {{(DW-SEL_W){1'b0}}, sel_word}; // [R4]
            end
            {OP_PCS_WR, 3'h3}: begin
               step_kind = STP_CMD_WR;
               step_val = cmd_word(MIIM_ADDR_ADDR, 1'b1); // [R4]
            end
            {OP_PCS_WR, 3'h4}: step_kind = STP_POLL_WR; // [R3]
            {OP_PCS_RD, 3'h0}: begin
               step_kind = STP_DATA_WR;
               step_val = {{(DW-SEL_W){1'b0}}, sel_word}; // [R9]
            end
            {OP_PCS_RD, 3'h1}: begin
               step_kind = STP_CMD_WR;
               step_val = cmd_word(MIIM_ADDR_ADDR, 1'b0); // [R9]
            end
            {OP_PCS_RD, 3'h2}: step_kind = STP_POLL_RD; // [R9] [R10]
            {OP_PCS_RD, 3'h3}: step_kind = STP_DATA_RD; // [R9]
            default: step_kind = STP_END;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // apb slave
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel & penable & !pready;
         pslverr <= psel & penable & !pready & !mapped;
         prdata <= '0;
         if (apb_re) begin
            case (paddr)
               A_CTRL: prdata <= {{(DW-OPW){1'b0}}, op};
               A_TADDR: prdata <= {{(DW-MAW){1'b0}}, taddr};
               A_SEL: prdata <= {{(DW-SEL_W){1'b0}}, sel_word};
               A_WDATA: prdata <= wdata_reg;
               A_RDATA: prdata <= rd_result;
               A_STATUS: begin
                  prdata[ST_BUSY_BIT] <= busy;
                  prdata[ST_DONE_BIT] <= done;
                  prdata[ST_CFG_BIT] <= cfg_done;
               end
               A_CFGW: prdata <= cfg_word;
               default: prdata <= '0;
            endcase
         end
      end
   end

   // parameter registers, frozen while an order runs
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         taddr <= '0;
         phy_select <= '0;
         reg_num <= '0;
         wdata_reg <= '0;
         cfg_word <= CFG_WORD_DEF;
      end else if (apb_we & !busy) begin
         case (paddr)
            A_TADDR: taddr <= pwdata[MAW-1:0];
            A_SEL: begin
               phy_select <= pwdata[SEL_PHY_LSB +: SEL_FW];
               reg_num <= pwdata[SEL_REG_LSB +: SEL_FW];
            end
            A_WDATA: wdata_reg <= pwdata;
            A_CFGW: cfg_word <= pwdata;
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // sequencer over the link
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state <= HS_IDLE;
         op <= OP_MAC_WR;
         step <= '0;
         busy <= 1'b0;
         cfg_done <= 1'b0;
         cfg_phase <= 1'b0;
         rd_result <= '0;
         lk_req <= 1'b0;
         lk_wr <= 1'b0;
         lk_addr <= '0;
         lk_wdata <= '0;
      end else begin
         case (state)
            HS_IDLE: begin
               if (wr_ctrl) begin
                  op <= pwdata[OPW-1:0];
                  step <= '0;
                  busy <= 1'b1;
                  // pcs access only after the config word went out
                  cfg_phase <= pwdata[OPW-1] & !cfg_done; // [R6]
                  state <= HS_ISSUE;
               end
            end
            HS_ISSUE: begin
               if (step_kind == STP_END) begin
                  step <= '0;
                  if (cfg_phase) begin
                     cfg_phase <= 1'b0;
                     cfg_done <= 1'b1;
                  end else begin
                     busy <= 1'b0;
                     state <= HS_IDLE;
                  end
               end else begin
                  lk_req <= 1'b1;
                  lk_wr <= step_kind == STP_DATA_WR
                     | step_kind == STP_CMD_WR;
                  if (step_kind == STP_CMD_WR) begin
                     lk_addr <= LINK_BASE + OFS_CMD; // [R11]
                  end else if (step_kind == STP_POLL_WR
                     | step_kind == STP_POLL_RD) begin
                     lk_addr <= LINK_BASE + OFS_RDY;
                  end else begin
                     lk_addr <= LINK_BASE + OFS_DATA; // [R11]
                  end
                  lk_wdata <= step_val;
                  state <= HS_WAIT;
               end
            end
            HS_WAIT: begin
               if (lk.ack) begin
                  lk_req <= 1'b0;
                  state <= HS_ISSUE;
                  case (step_kind)
                     STP_POLL_WR: begin
                        if (lk.rdata[RDY_WR_BIT]) begin
                           step <= step + 1'b1; // [R3]
                        end
                     end
                     STP_POLL_RD: begin
                        if (lk.rdata[RDY_RD_BIT]) begin
                           step <= step + 1'b1; // [R10]
                        end
                     end
                     STP_DATA_RD: begin
                        rd_result <= lk.rdata; // [R9]
                        step <= step + 1'b1;
                     end
                     default: step <= step + 1'b1;
                  endcase
               end
            end
            default: state <= HS_IDLE;
         endcase
      end
   end

   // sticky done: completion wins over a same-cycle clear
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         done <= 1'b0;
      end else begin
         done <= end_set | (done & !clr_done);
      end
   end
endmodule

// file: dv/kh_link_monitor.sv
// Purpose: handshake and ready-bit checks on the link and mgmt port
// Assumes: one clock, nrst synchronous active low
// Notes: instantiated beside the link, no bind
`timescale 1ns/1ps
module kh_link_monitor
   import kh_pkg::*;
#(
   parameter logic [kh_pkg::LAW-1:0] LINK_BASE = kh_pkg::LK_BASE_DEF
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic req,
   input wire logic wr,
   input wire logic [kh_pkg::LAW-1:0] addr,
   input wire logic [kh_pkg::DW-1:0] wdata,
   input wire logic [kh_pkg::DW-1:0] rdata,
   input wire logic ack,
   input wire logic mgmt_req,
   input wire logic mgmt_wr,
   input wire logic [kh_pkg::MAW-1:0] mgmt_addr,
   input wire logic [kh_pkg::DW-1:0] mgmt_wdata,
   input wire logic mgmt_ack
);
   logic [MAW-1:0] cmd_q;
   logic cmd_wr;
   logic rdy_rd;
   assign cmd_wr = req && ack && wr && addr == LINK_BASE + OFS_CMD
      && wdata[CMD_WR_BIT] && !wdata[CMD_PCS_BIT];
   assign rdy_rd = req && ack && !wr && addr == LINK_BASE + OFS_RDY;
   always_ff @(posedge ref_clk) begin
      if (!nrst)
         cmd_q <= '0;
      else if (cmd_wr)
         cmd_q <= wdata[MAW-1:0];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////
   chk_ack_with_req: assert property (ack |-> req)
      else $error("link ack without request");
   chk_ack_single: assert property (ack |=> !ack)
      else $error("link ack longer than one cycle");
   chk_req_stable: assert property (req && !ack |=>
      req && $stable(addr) && $stable(wr) && $stable(wdata))
      else $error("link request changed before ack");
   chk_req_release: assert property (ack |=> !req)
      else $error("link request not dropped after ack");
   chk_ack_bound: assert property (req |-> ##[0:60] ack)
      else $error("link request never answered");
   chk_mgmt_stable: assert property (mgmt_req && !mgmt_ack |=>
      mgmt_req && $stable(mgmt_addr) && $stable(mgmt_wdata))
      else $error("mgmt request changed before ack");
   chk_mgmt_release: assert property (mgmt_req && mgmt_ack |=> !mgmt_req)
      else $error("mgmt request held after ack");
   chk_write_cmd: assert property (cmd_wr |-> ##[1:6]
      (mgmt_req && mgmt_wr && mgmt_addr == cmd_q))
      else $error("write command gave no mgmt write");
   chk_rd_busy: assert property (rdy_rd && $past(mgmt_req)
      && !$past(mgmt_wr) && $past(mgmt_addr) == MIIM_ADDR_ADDR
      |-> !rdata[RDY_RD_BIT])
      else $error("read ready shown during pcs read");
   chk_wr_busy: assert property (rdy_rd && $past(mgmt_req)
      && $past(mgmt_wr) |-> !rdata[RDY_WR_BIT])
      else $error("write ready shown during mgmt write");
   cover property (cmd_wr);
   cover property (rdy_rd && !rdata[RDY_RD_BIT]);
   cover property (mgmt_req && mgmt_ack && !mgmt_wr);
endmodule

// file: dv/tb.sv
// Purpose: drives the controller over apb, plays the mac behind the bridge
// Assumes: controller and bridge joined through the link interface
// Notes: mac acks after a random 0..3 cycle delay
`timescale 1ns/1ps
module tb;
   import kh_pkg::*;
   logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
   logic [PAW-1:0] paddr;
   logic [DW-1:0] pwdata, prdata, mgmt_wdata, mgmt_rdata, rv, d, sel;
   logic mgmt_req, mgmt_wr, mgmt_ack;
   logic [MAW-1:0] mgmt_addr, a;
   logic [DW-1:0] mac_mem [1024];
   logic [DW-1:0] pcs_mem [1024];
   logic [31:0] seed = 32'h59D83E73;
   int n_errors = 0, samples_checked = 0, cyc = 0, dly = 0;
   kh_link_if lk ();
   kh_ctrl_host kh_ctrl_host_i (.ref_clk(ref_clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lk(lk));
   kh_bridge_dev kh_bridge_dev_i (.ref_clk(ref_clk), .nrst(nrst), .lk(lk),
      .mgmt_req(mgmt_req), .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr),
      .mgmt_wdata(mgmt_wdata), .mgmt_ack(mgmt_ack),
      .mgmt_rdata(mgmt_rdata));
   kh_link_monitor kh_link_monitor_i (.ref_clk(ref_clk), .nrst(nrst),
      .req(lk.req), .wr(lk.wr), .addr(lk.addr), .wdata(lk.wdata),
      .rdata(lk.rdata), .ack(lk.ack), .mgmt_req(mgmt_req),
      .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
      .mgmt_ack(mgmt_ack));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [DW-1:0] sel_of(input logic [4:0] ph,
      input logic [4:0] rg);
      return DW'(ph) << SEL_PHY_LSB | DW'(rg) << SEL_REG_LSB;
   endfunction
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////
   // mac model; pcs reg takes the staged word when the selector lands
   always @(posedge ref_clk) begin
      if (!nrst) begin
         mgmt_ack <= 1'b0;
         mgmt_rdata <= '0;
         dly <= 0;
      end else if (mgmt_req && !mgmt_ack && dly != 0) begin
         dly <= dly - 1;
      end else if (mgmt_req && !mgmt_ack) begin
         mgmt_ack <= 1'b1;
         dly <= int'(xs() % 4);
         if (mgmt_wr) begin
            mac_mem[mgmt_addr] <= mgmt_wdata;
            if (mgmt_addr == MIIM_ADDR_ADDR)
               pcs_mem[mgmt_wdata[SEL_W-1:0]] <= mac_mem[MIIM_WDATA_ADDR];
         end else if (mgmt_addr == MIIM_ADDR_ADDR)
            mgmt_rdata <= pcs_mem[mgmt_wdata[SEL_W-1:0]];
         else
            mgmt_rdata <= mac_mem[mgmt_addr];
      end else begin
         mgmt_ack <= 1'b0;
         mgmt_rdata <= ~mgmt_rdata;
      end
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////
   // pready sampled at the rising edge, before the slave's update lands
   task apb(input logic w, input logic [PAW-1:0] ad,
      input logic [DW-1:0] wd);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // a hung order is caught by the cycle ceiling, not here
   task run_op(input logic [OPW-1:0] op);
      apb(1'b1, A_CTRL, DW'(op));
      do begin
         apb(1'b0, A_STATUS, '0);
      end while (rv[ST_BUSY_BIT] !== 1'b0);
   endtask
   task chk32(input string nm, input logic [DW-1:0] e,
      input logic [DW-1:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk1(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s expected %b seen %b", nm, e, g);
      end
   endtask
   task end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      apb(1'b0, A_CFGW, '0);
      chk32("cfg word reset", CFG_WORD_DEF, rv);
      apb(1'b0, 8'h1C, '0);
      chk1("unmapped error", 1'b1, er);
      chk32("unmapped data", '0, rv);
      $display("test reset_map done");
      for (int i = 0; i < 4; i++) begin
         a = MAW'(xs() % 32'h300);
         d = xs();
         apb(1'b1, A_TADDR, DW'(a));
         apb(1'b1, A_WDATA, d);
         run_op(OP_MAC_WR);
         chk32("mac write", d, mac_mem[a]);
         chk1("done flag", 1'b1, rv[ST_DONE_BIT]);
         apb(1'b1, A_STATUS, 32'h00000002);
         apb(1'b0, A_STATUS, '0);
         chk1("done clear", 1'b0, rv[ST_DONE_BIT]);
         a = a ^ 10'h001;
         d = xs();
         mac_mem[a] = d;
         apb(1'b1, A_TADDR, DW'(a));
         run_op(OP_MAC_RD);
         apb(1'b0, A_RDATA, '0);
         chk32("mac read", d, rv);
      end
      $display("test mac_access done");
      for (int i = 0; i < 3; i++) begin
         d = xs();
         sel = sel_of(5'h01, d[4:0]);
         d = xs();
         apb(1'b1, A_SEL, sel);
         apb(1'b1, A_WDATA, d);
         run_op(OP_PCS_WR);
         chk32("pcs write", d, pcs_mem[sel[SEL_W-1:0]]);
         run_op(OP_PCS_RD);
         apb(1'b0, A_RDATA, '0);
         chk32("pcs read", d, rv);
      end
      chk32("cfg word sent", CFG_WORD_DEF, mac_mem[MGMT_CFG_ADDR]);
      apb(1'b0, A_STATUS, '0);
      chk1("cfg done", 1'b1, rv[ST_CFG_BIT]);
      $display("test pcs_access done");
      end_of_test();
   end
endmodule
